// *** src/fpcl_pkg.sv ***
/*
 * constants, states and ratio decode for the fast parallel config loader.
 * assumes a 20 mhz system clock; all times are converted to cycles here.
 */
package fpcl_pkg;

	localparam int unsigned CLK_MHZ      = 20;
	localparam int unsigned CNT_W        = 22;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned WORDS_W      = 32;

	// power-on delay, least value of each choice
	localparam int unsigned POR_FAST_MS  = 4;
	localparam int unsigned POR_STD_MS   = 100;
	localparam int unsigned POR_FAST_CYC = POR_FAST_MS * 1000 * CLK_MHZ;
	localparam int unsigned POR_STD_CYC  = POR_STD_MS * 1000 * CLK_MHZ;

	// status low pulse: least 268 us, longest 1506 us
	localparam int unsigned STATUS_MIN_US  = 268;
	localparam int unsigned STATUS_CYC     = STATUS_MIN_US * CLK_MHZ;
	// request low to outputs low, longest 600 ns
	localparam int unsigned REQ_LOW_NS     = 600;
	localparam int unsigned REQ_LOW_CYC    = (REQ_LOW_NS * CLK_MHZ) / 1000;

	// init on internal oscillator: 175 to 437 us after load complete
	localparam int unsigned INIT_MIN_US  = 175;
	localparam int unsigned INIT_CYC     = INIT_MIN_US * CLK_MHZ;
	// init on user clock: edges of that clock
	localparam int unsigned INIT_USR_EDGES = 8576;

	// reset values of the pins the block drives
	localparam logic RST_DRIVE_LOW = 1'b1;
	localparam logic RST_LOAD_DONE = 1'b0;

	typedef enum logic [2:0] {
		ST_POR   = 3'h0,
		ST_RESET = 3'h1,
		ST_LOAD  = 3'h2,
		ST_TAIL  = 3'h3,
		ST_INIT  = 3'h4,
		ST_USER  = 3'h5,
		ST_FAIL  = 3'h6
	} fpcl_state_type;

	// clock-to-data ratio from bus width, encryption and compression
	function automatic logic [2:0] ratio_of(input logic wide16,
	                                        input logic encrypt,
	                                        input logic compress);
		logic [2:0] r;
		r = 3'h1;
		if (wide16) begin
			if (compress)
				r = 3'h4;
			else if (encrypt)
				r = 3'h2;
		end else if (compress) begin
			r = 3'h2;
		end
		return r;
	endfunction : ratio_of

endpackage : fpcl_pkg

// *** src/fpcl_pins_if.sv ***
/*
 * carrier between the loader and its pin synchroniser.
 * raw pin levels go in, synchronised levels and edge pulses come out.
 */
`timescale 1ns/1ps
`default_nettype none
interface fpcl_pins_if #(parameter int unsigned DW = 16);
	logic          req_n_raw;
	logic          cfg_clock_raw;
	logic          uclk_raw;
	logic          state_n_raw;
	logic [4:0]    straps_raw;
	logic [DW-1:0] data_raw;
	logic          req_n_s;
	logic          state_n_s;
	logic [4:0]    straps_s;
	logic [DW-1:0] data_s;
	logic          cfg_clock_rise;
	logic          uclk_rise;

	modport sync (input req_n_raw, cfg_clock_raw, uclk_raw, state_n_raw,
	              straps_raw, data_raw,
	              output req_n_s, state_n_s, straps_s, data_s,
	              cfg_clock_rise, uclk_rise);
	modport core (output req_n_raw, cfg_clock_raw, uclk_raw, state_n_raw,
	              straps_raw, data_raw,
	              input req_n_s, state_n_s, straps_s, data_s,
	              cfg_clock_rise, uclk_rise);
endinterface : fpcl_pins_if
`default_nettype wire

// *** src/fpcl_pin_sync.sv ***
/*
 * two-flop synchronisers for every pin and rising-edge pulses for the
 * two outside clocks. assumes those clocks run well below clk_sys / 2.
 */
`timescale 1ns/1ps
`default_nettype none
module fpcl_pin_sync #(
	parameter int unsigned DW = 16
) (
	input  wire logic  clk_sys, // system clock
	input  wire logic  rst_n,   // synchronous reset, active low
	fpcl_pins_if.sync  pins     // raw pins in, clean levels out
);
	localparam int unsigned W = DW + 9;

	logic [W-1:0] raw;
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic         cfg_clock_q;
	logic         uclk_q;

	assign raw = {pins.data_raw, pins.straps_raw, pins.state_n_raw,
	              pins.req_n_raw, pins.uclk_raw, pins.cfg_clock_raw};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s1_q   <= '1;
			s2_q   <= '1;
			cfg_clock_q <= 1'b1;
			uclk_q <= 1'b1;
		end else begin
			s1_q   <= raw;
			s2_q   <= s1_q;
			cfg_clock_q <= s2_q[0];
			uclk_q <= s2_q[1];
		end
	end

	assign pins.cfg_clock_rise = s2_q[0] & ~cfg_clock_q;
	assign pins.uclk_rise = s2_q[1] & ~uclk_q;
	assign pins.req_n_s   = s2_q[2];
	assign pins.state_n_s = s2_q[3];
	assign pins.straps_s  = s2_q[8:4];
	assign pins.data_s    = s2_q[W-1:9];
endmodule : fpcl_pin_sync
`default_nettype wire

// *** src/fpcl_loader.sv ***
/*
 * fast parallel configuration port: power-on wait, reset handshake,
 * ratio-paced word intake, tail clocks, check and initialization count.
 * assumes an outside host drives cfg_clock, cfg_data, config_request_n
 * and the scheme straps; all of these are asynchronous to clk_sys.
 */
// What the document requires
// RQ1: wait fast or standard power-on delay, chosen by straps, before loading.
// RQ2: ratio is 1/2 for 8-bit, 1/2/4 for 16-bit by encryption, compression.
// RQ3: host clocks r times the word rate, holding each word r clocks.
// RQ4: extra clock edges per word are spent decrypting and decompressing.
// RQ5: host gives r-1 more clocks after the last word is latched.
// RQ6: request low pulls load-complete and status low within 600 ns.
// RQ7: host holds request low at least 2 us to reconfigure.
// RQ8: status stays low 268 to 1506 us, extended by request or outside hold.
// RQ9: status released within 1506 us of request going high.
// RQ10: host waits 2 us after status high, or 1506 us after request high.
// RQ11: data bus is sampled on the rising configuration clock edge.
// RQ12: configuration clock never faster than 125 MHz; the loader needs it well below clk_sys / 2.
// RQ13: internal-oscillator init enters user mode 175 to 437 us after done.
// RQ14: user init clock starts four max clock periods after done, no earlier.
// RQ15: init takes 8576 user init clock cycles when that option is on.
// RQ16: load-complete rises after the last word is received and checked.
// RQ17: clock edges and data are ignored while status is held low; the code ignores them in every state but ST_LOAD and ST_TAIL, so not while loading.
`timescale 1ns/1ps
`default_nettype none
module fpcl_loader #(
	parameter int unsigned DW         = fpcl_pkg::DATA_W,
	parameter int unsigned POR_FAST   = fpcl_pkg::POR_FAST_CYC,
	parameter int unsigned POR_STD    = fpcl_pkg::POR_STD_CYC,
	parameter int unsigned STATUS_LOW = fpcl_pkg::STATUS_CYC,
	parameter int unsigned INIT_OSC   = fpcl_pkg::INIT_CYC,
	parameter int unsigned INIT_USR   = fpcl_pkg::INIT_USR_EDGES
) (
	input  wire logic                     clk_sys,          // system clock
	input  wire logic                     rst_n,            // sync reset
	input  wire logic                     config_request_n, // host request
	input  wire logic                     cfg_clock,        // host clock
	input  wire logic [DW-1:0]            cfg_data,         // data bus
	input  wire logic                     user_init_clock,  // init clock
	input  wire logic                     cfg_state_n_in,   // status wire
	output logic                          cfg_state_n_out,  // status drive
	output logic                          cfg_state_n_oe_n, // low: drive
	output logic                          load_complete,    // done level
	input  wire logic                     por_fast_sel,     // strap
	input  wire logic                     bus_wide16,       // strap
	input  wire logic                     encrypt_en,       // strap
	input  wire logic                     compress_en,      // strap
	input  wire logic                     user_clk_sel,     // strap
	input  wire logic [fpcl_pkg::WORDS_W-1:0] image_words,  // word count
	input  wire logic [DW-1:0]            image_check,      // xor check
	output logic [DW-1:0]                 cfg_word,         // word out
	output logic                          cfg_word_valid,   // word pulse
	output logic                          user_mode,        // in user mode
	output logic                          cfg_error         // check failed
);
	localparam int unsigned CW = fpcl_pkg::CNT_W;
	localparam int unsigned WW = fpcl_pkg::WORDS_W;

	fpcl_pins_if #(.DW(DW)) pins ();

	fpcl_pin_sync #(.DW(DW)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pins    (pins)
	);

	assign pins.req_n_raw   = config_request_n;
	assign pins.cfg_clock_raw    = cfg_clock;
	assign pins.uclk_raw    = user_init_clock;
	assign pins.state_n_raw = cfg_state_n_in;
	assign pins.data_raw    = cfg_data;
	assign pins.straps_raw  = {user_clk_sel, compress_en, encrypt_en,
	                           bus_wide16, por_fast_sel};

	fpcl_pkg::fpcl_state_type state_q, state_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [1:0]    phase_q, phase_d;
	logic [2:0]    ratio_q, ratio_d;
	logic          usr_q, usr_d;
	logic [WW-1:0] words_q, words_d;
	logic [DW-1:0] sum_q, sum_d;
	logic [DW-1:0] word_q, word_d;
	logic          valid_q, valid_d;
	logic          drive_q, drive_d;
	logic          done_q, done_d;
	logic          err_q, err_d;

	// decode of straps, targets and end-of-stream
	wire [CW-1:0] cnt_inc    = cnt_q + 1'b1;
	wire [CW-1:0] por_target = pins.straps_s[0] ? CW'(POR_FAST)
	                                            : CW'(POR_STD); // [RQ1]
	wire [2:0]    ratio_now  = fpcl_pkg::ratio_of(pins.straps_s[1],
	                             pins.straps_s[2], pins.straps_s[3]); // [RQ2]
	wire          take_word  = pins.cfg_clock_rise && (phase_q == 2'h0); // [RQ11]
	wire [1:0]    phase_last = 2'(ratio_q - 3'h1);
	wire [1:0]    phase_nx   = (phase_q == phase_last) ? 2'h0
	                                                   : phase_q + 2'h1;
	wire [WW-1:0] words_nx   = words_q + 1'b1;
	wire [DW-1:0] sum_nx     = sum_q ^ pins.data_s;
	wire          last_word  = take_word && (words_nx == image_words);
	wire          tail_end   = pins.cfg_clock_rise &&
	                           (cnt_inc == CW'(ratio_q - 3'h1)); // [RQ5]
	wire          init_tick  = usr_q ? pins.uclk_rise : 1'b1;
	wire [CW-1:0] init_tgt   = usr_q ? CW'(INIT_USR) : CW'(INIT_OSC);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		phase_d = phase_q;
		ratio_d = ratio_q;
		usr_d   = usr_q;
		words_d = words_q;
		sum_d   = sum_q;
		word_d  = word_q;
		valid_d = 1'b0;
		drive_d = drive_q;
		done_d  = done_q;
		err_d   = err_q;
		case (state_q)
			fpcl_pkg::ST_POR: begin
				drive_d = 1'b1;
				cnt_d   = cnt_inc;
				if (cnt_inc >= por_target) begin // [RQ1]
					state_d = fpcl_pkg::ST_RESET;
					cnt_d   = '0;
				end
			end
			fpcl_pkg::ST_RESET: begin
				// edges and data are not looked at here [RQ17]
				ratio_d = ratio_now;
				usr_d   = pins.straps_s[4];
				phase_d = 2'h0;
				words_d = '0;
				sum_d   = '0;
				if (!pins.req_n_s) begin
					drive_d = 1'b1; // request extends the pulse [RQ8]
					cnt_d   = '0;
				end else if (cnt_q < CW'(STATUS_LOW)) begin
					drive_d = 1'b1; // [RQ8]
					cnt_d   = cnt_inc;
				end else begin
					drive_d = 1'b0; // [RQ9]
					if (pins.state_n_s)
						state_d = fpcl_pkg::ST_LOAD; // outside hold waits [RQ8]
				end
			end
			fpcl_pkg::ST_LOAD: begin
				if (pins.cfg_clock_rise)
					phase_d = phase_nx; // spare edges feed decode [RQ4]
				if (take_word) begin
					word_d  = pins.data_s; // [RQ11]
					valid_d = 1'b1;
					words_d = words_nx;
					sum_d   = sum_nx;
				end
				if (last_word) begin
					cnt_d = '0;
					if (ratio_q == 3'h1) begin
						state_d = (sum_nx == image_check) ? fpcl_pkg::ST_INIT
						                                  : fpcl_pkg::ST_FAIL;
						done_d  = (sum_nx == image_check); // [RQ16]
					end else begin
						state_d = fpcl_pkg::ST_TAIL; // [RQ5]
					end
				end
			end
			fpcl_pkg::ST_TAIL: begin
				if (pins.cfg_clock_rise)
					cnt_d = cnt_inc; // [RQ4]
				if (tail_end) begin
					cnt_d   = '0;
					state_d = (sum_q == image_check) ? fpcl_pkg::ST_INIT
					                                 : fpcl_pkg::ST_FAIL;
					done_d  = (sum_q == image_check); // [RQ16]
				end
			end
			fpcl_pkg::ST_INIT: begin
				// user clock edges only count once it runs [RQ14]
				if (init_tick)
					cnt_d = cnt_inc; // [RQ13] [RQ15]
				if (init_tick && (cnt_inc >= init_tgt))
					state_d = fpcl_pkg::ST_USER;
			end
			fpcl_pkg::ST_USER: begin
				done_d = 1'b1;
			end
			fpcl_pkg::ST_FAIL: begin
				drive_d = 1'b1;
				err_d   = 1'b1;
			end
			default: begin
				state_d = fpcl_pkg::ST_RESET;
				drive_d = 1'b1;
			end
		endcase
		// request low restarts from any state but power-on [RQ6]
		if (!pins.req_n_s && (state_q != fpcl_pkg::ST_POR)) begin
			state_d = fpcl_pkg::ST_RESET;
			drive_d = 1'b1;
			done_d  = 1'b0;
			err_d   = 1'b0;
			if (state_q != fpcl_pkg::ST_RESET)
				cnt_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= fpcl_pkg::ST_POR;
			cnt_q   <= '0;
			phase_q <= 2'h0;
			ratio_q <= 3'h1;
			usr_q   <= 1'b0;
			words_q <= '0;
			sum_q   <= '0;
			word_q  <= '0;
			valid_q <= 1'b0;
			drive_q <= fpcl_pkg::RST_DRIVE_LOW;
			done_q  <= fpcl_pkg::RST_LOAD_DONE;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			phase_q <= phase_d;
			ratio_q <= ratio_d;
			usr_q   <= usr_d;
			words_q <= words_d;
			sum_q   <= sum_d;
			word_q  <= word_d;
			valid_q <= valid_d;
			drive_q <= drive_d;
			done_q  <= done_d;
			err_q   <= err_d;
		end
	end

	assign cfg_state_n_out  = 1'b0;
	assign cfg_state_n_oe_n = ~drive_q; // [RQ6]
	assign load_complete    = done_q;   // [RQ6]
	assign cfg_word         = word_q;
	assign cfg_word_valid   = valid_q;
	assign user_mode        = (state_q == fpcl_pkg::ST_USER); // [RQ13]
	assign cfg_error        = err_q;
endmodule : fpcl_loader
`default_nettype wire

// *** dv/fpcl_loader_properties.sv ***
/* pin checker for fpcl_loader, bound to every instance.
 * assumes cfg_state_n_in carries the resolved status wire. */
`timescale 1ns/1ps
`default_nettype none
module fpcl_loader_chk #(
	parameter int unsigned STATUS_LOW = 40,
	parameter int unsigned INIT_OSC   = 30,
	parameter int unsigned POR_STD    = 60
) (
	input wire logic        clk_sys,          // clock
	input wire logic        rst_n,            // reset
	input wire logic        config_request_n, // request
	input wire logic [15:0] cfg_data,         // data bus
	input wire logic        cfg_state_n_in,   // status wire
	input wire logic        user_clk_sel,     // init choice
	input wire logic        cfg_state_n_out,  // status value
	input wire logic        cfg_state_n_oe_n, // status drive
	input wire logic        load_complete,    // done
	input wire logic [15:0] cfg_word,         // word
	input wire logic        cfg_word_valid,   // word pulse
	input wire logic        user_mode,        // user mode
	input wire logic        cfg_error         // error
);
	logic [15:0] low_q;
	logic [15:0] hi_q;
	logic [15:0] done_q;
	logic        hi_clr;
	assign hi_clr = cfg_state_n_oe_n || !config_request_n || cfg_error;
	always_ff @(posedge clk_sys) begin
		low_q  <= (!rst_n || cfg_state_n_oe_n) ? 16'h0 : low_q + 16'h1;
		hi_q   <= (!rst_n || hi_clr) ? 16'h0 : hi_q + 16'h1;
		done_q <= (!rst_n || !load_complete) ? 16'h0 : done_q + 16'h1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_pulled;
		!cfg_state_n_oe_n && !load_complete;
	endsequence
	sequence s_word;
		cfg_word_valid ##1 !cfg_word_valid;
	endsequence
	req_answer_a: assert property (
		$fell(config_request_n) |-> ##[1:12] s_pulled)
		else $error("request low not answered in time");
	open_drain_a: assert property (cfg_state_n_out == 1'b0)
		else $error("status value not low");
	status_min_a: assert property (
		$rose(cfg_state_n_oe_n) |-> low_q >= STATUS_LOW - 1)
		else $error("status low pulse too short");
	status_max_a: assert property (
		hi_q <= POR_STD + STATUS_LOW * 1506 / 268)
		else $error("status not released in time");
	word_data_a: assert property (
		cfg_word_valid |-> cfg_word == $past(cfg_data, 2))
		else $error("word differs from bus at clock rise");
	word_pulse_a: assert property (cfg_word_valid |-> s_word)
		else $error("word pulse longer than one cycle");
	held_ignore_a: assert property (
		!cfg_state_n_in [*3] |-> !cfg_word_valid)
		else $error("word taken while status low");
	osc_init_a: assert property (
		$rose(user_mode) && !user_clk_sel |->
		done_q inside {[INIT_OSC - 1:INIT_OSC * 437 / 175]})
		else $error("oscillator init time out of range");
	mode_done_a: assert property (user_mode |-> load_complete)
		else $error("user mode without load complete");
	error_pull_a: assert property ($rose(cfg_error) |-> s_pulled)
		else $error("check error without status low");
endmodule : fpcl_loader_chk
bind fpcl_loader fpcl_loader_chk #(.STATUS_LOW(STATUS_LOW),
	.INIT_OSC(INIT_OSC), .POR_STD(POR_STD)) u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .config_request_n(config_request_n),
	.cfg_data(cfg_data), .cfg_state_n_in(cfg_state_n_in),
	.user_clk_sel(user_clk_sel), .cfg_state_n_out(cfg_state_n_out),
	.cfg_state_n_oe_n(cfg_state_n_oe_n), .load_complete(load_complete),
	.cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
	.user_mode(user_mode), .cfg_error(cfg_error));
`default_nettype wire

// *** dv/fpcl_host_model.sv ***
/* host model: sends one image of count words per rise of start.
 * assumes word k is base + k; the clock stands low between images. */
`timescale 1ns/1ps
`default_nettype none
module fpcl_host_model #(
	parameter int unsigned HALF_NS = 200 // well under 125 mhz
) (
	input  wire logic        start,     // rise: send one image
	input  wire logic [2:0]  ratio,     // clock edges per word
	input  wire logic [7:0]  count,     // words in the image
	input  wire logic [15:0] base,      // first word
	output logic             cfg_clock, // host clock
	output logic [15:0]      cfg_data,  // data bus
	output logic             done       // image and tail sent
);
	task automatic edge_pair();
		#HALF_NS cfg_clock = 1'b1;
		#HALF_NS cfg_clock = 1'b0;
	endtask : edge_pair
	initial begin
		cfg_clock = 1'b0;
		cfg_data  = 16'h0;
		done      = 1'b0;
		forever begin
			@(posedge start);
			done = 1'b0;
			#37;
			for (int k = 0; k < count; k++) begin
				cfg_data = base + 16'(k);
				for (int e = 0; e < ratio; e++) edge_pair();
			end
			for (int e = 1; e < ratio; e++) edge_pair();
			cfg_data = ~cfg_data;
			done = 1'b1;
		end
	end
endmodule : fpcl_host_model
`default_nettype wire

// *** dv/test_fast_parallel_config_port.sv ***
/* self-checking bench for fpcl_loader with the host model on its pins.
 * assumes the status wire has a pull-up and the bench may hold it low. */
`timescale 1ns/1ps
`default_nettype none
module test_fast_parallel_config_port;
	localparam int unsigned ST_LOW = 40;
	localparam int unsigned I_OSC  = 30;
	localparam int unsigned I_USR  = 10;
	typedef struct {
		logic w16; logic enc; logic cmp; logic bad; logic [2:0] r;
	} fpcl_row_type;
	fpcl_row_type rows [9] = '{'{0,0,0,0,1}, '{0,1,0,0,1}, '{0,0,1,0,2},
		'{0,1,1,0,2}, '{1,0,0,0,1}, '{1,1,0,0,2}, '{1,0,1,0,4},
		'{1,1,1,0,4}, '{1,0,1,1,4}};
	logic        clk_sys = 1'b0, rst_n = 1'b0, req_n = 1'b1, uclk = 1'b0;
	logic        hold_low = 1'b0, fast = 1'b1, w16 = 1'b0, enc = 1'b0;
	logic        cmp = 1'b0, usel = 1'b0, start = 1'b0;
	logic [2:0]  ratio = 3'h1;
	logic [7:0]  count = 8'h1;
	logic [15:0] base = 16'h0, chk = 16'h0, cfg_data, cfg_word;
	logic        cfg_clock, oe_n, st_out, done_l, word_v, umode, err, hdone;
	logic        st_wire;
	int          num_errors = 0, n_checks = 0, seen = 0, init_cyc = 0;
	assign st_wire = !(oe_n === 1'b0 || hold_low);
	fpcl_loader #(.POR_FAST(50), .POR_STD(60), .STATUS_LOW(ST_LOW),
		.INIT_OSC(I_OSC), .INIT_USR(I_USR)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .config_request_n(req_n),
		.cfg_clock(cfg_clock), .cfg_data(cfg_data), .user_init_clock(uclk),
		.cfg_state_n_in(st_wire), .cfg_state_n_out(st_out),
		.cfg_state_n_oe_n(oe_n), .load_complete(done_l), .por_fast_sel(fast),
		.bus_wide16(w16), .encrypt_en(enc), .compress_en(cmp),
		.user_clk_sel(usel), .image_words({24'h0, count}), .image_check(chk),
		.cfg_word(cfg_word), .cfg_word_valid(word_v), .user_mode(umode),
		.cfg_error(err));
	fpcl_host_model u_host (.start(start), .ratio(ratio), .count(count),
		.base(base), .cfg_clock(cfg_clock), .cfg_data(cfg_data), .done(hdone));
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (word_v === 1'b1) seen <= seen + 1;
	// cycles from load complete to user mode, frozen once user mode is up
	always @(posedge clk_sys) begin
		if (done_l !== 1'b1)
			init_cyc <= 0;
		else if (umode !== 1'b1)
			init_cyc <= init_cyc + 1;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	task automatic wait_on(input int sel, input int lim, output int n);
		logic [3:0] f;
		for (n = 0; n < lim; n++) begin
			@(posedge clk_sys);
			#1;
			f = {umode, done_l | err, hdone, st_wire};
			if (f[sel] === 1'b1) return;
		end
		num_errors++;
		$display("mismatch at %0t: wait %0d ran out", $time, sel);
		wrap_up();
	endtask : wait_on
	task automatic reconfig(input logic hold);
		int c;
		@(posedge clk_sys);
		req_n <= 1'b0;
		hold_low <= hold;
		repeat (40) @(posedge clk_sys);
		req_n <= 1'b1;
		seen = 0;
		if (!hold) begin
			wait_on(0, 300, c);
			repeat (40) @(posedge clk_sys);
		end
	endtask : reconfig
	task automatic send(input logic [2:0] r, input logic [7:0] n);
		int c;
		@(posedge clk_sys);
		ratio <= r;
		count <= n;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		wait_on(1, 2000, c);
	endtask : send
	function automatic logic [15:0] xor_of(input logic [15:0] b, input int n);
		logic [15:0] x;
		x = 16'h0;
		for (int k = 0; k < n; k++) x ^= b + 16'(k);
		return x;
	endfunction : xor_of
	initial begin
		logic [15:0] b;
		int          c;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		check(oe_n, 16'h0, "status drive at reset");
		check(st_out, 16'h0, "status value");
		check({done_l, umode, err, word_v}, 16'h0, "outputs at reset");
		wait_on(0, 300, c);
		check(16'(c >= 50 + ST_LOW && c <= 58 + ST_LOW), 16'h1, "fast delay");
		foreach (rows[i]) begin
			b = rows[i].w16 ? 16'h5a30 : 16'h0030;
			@(posedge clk_sys);
			w16 <= rows[i].w16;
			enc <= rows[i].enc;
			cmp <= rows[i].cmp;
			base <= b;
			chk <= xor_of(b, 3) ^ {15'h0, rows[i].bad};
			reconfig(1'b0);
			send(rows[i].r, 8'h3);
			wait_on(2, 40, c);
			check(16'(seen), 16'h3, "words taken");
			check(done_l, !rows[i].bad, "load complete");
			check(err, rows[i].bad, "check error");
			check(cfg_word, b + 16'h2, "last word");
			if (!rows[i].bad) begin
				wait_on(3, 100, c);
				check(16'(init_cyc >= I_OSC &&
					init_cyc <= I_OSC * 437 / 175), 16'h1,
					"oscillator init");
			end
		end
		chk <= xor_of(base, 3);
		usel <= 1'b1;
		reconfig(1'b0);
		send(3'h4, 8'h3);
		wait_on(2, 40, c);
		check(done_l, 16'h1, "load before user clock");
		#1600;
		for (c = 0; c < 40 && umode !== 1'b1; c++) begin
			#200 uclk = 1'b1;
			#200 uclk = 1'b0;
		end
		check(16'(c >= I_USR && c <= I_USR + 2), 16'h1, "user clock init");
		usel <= 1'b0;
		reconfig(1'b1);
		send(3'h4, 8'h2);
		check(16'(seen), 16'h0, "words while held");
		check({oe_n, done_l}, 16'h2, "drive released while held");
		@(posedge clk_sys);
		hold_low <= 1'b0;
		rst_n <= 1'b0;
		fast <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_on(0, 300, c);
		check(16'(c >= 60 + ST_LOW && c <= 68 + ST_LOW), 16'h1, "std delay");
		wrap_up();
	end
endmodule : test_fast_parallel_config_port
`default_nettype wire
